// File: core/drfsr_cfg.svh
/*
 Timing counts and limits for the refresh / self-refresh link.
 Assumes a 250 MHz controller clock; counts are in clock cycles.
*/
`ifndef DRFSR_CFG_SVH
`define DRFSR_CFG_SVH
`define DRFSR_CLK_PERIOD_PS          4000
`define DRFSR_REFI_NS                7800
`define DRFSR_REFI_CYC               ((`DRFSR_REFI_NS * 1000) / `DRFSR_CLK_PERIOD_PS)
`define DRFSR_RFC_NS                 160
`define DRFSR_RFC_CYC                ((`DRFSR_RFC_NS * 1000 + `DRFSR_CLK_PERIOD_PS - 1) / `DRFSR_CLK_PERIOD_PS)
`define DRFSR_RP_NS                  15
`define DRFSR_RP_CYC                 ((`DRFSR_RP_NS * 1000 + `DRFSR_CLK_PERIOD_PS - 1) / `DRFSR_CLK_PERIOD_PS)
`define DRFSR_CKE_MIN_NS             5
`define DRFSR_CKE_MIN_CYC            ((`DRFSR_CKE_MIN_NS * 1000 + `DRFSR_CLK_PERIOD_PS - 1) / `DRFSR_CLK_PERIOD_PS)
`define DRFSR_CKSRE_NS               10
`define DRFSR_CKSRE_CYC              ((`DRFSR_CKSRE_NS * 1000 + `DRFSR_CLK_PERIOD_PS - 1) / `DRFSR_CLK_PERIOD_PS)
`define DRFSR_CKSRX_NS               10
`define DRFSR_CKSRX_CYC              ((`DRFSR_CKSRX_NS * 1000 + `DRFSR_CLK_PERIOD_PS - 1) / `DRFSR_CLK_PERIOD_PS)
`define DRFSR_XS_NS                  170
`define DRFSR_XS_CYC                 ((`DRFSR_XS_NS * 1000 + `DRFSR_CLK_PERIOD_PS - 1) / `DRFSR_CLK_PERIOD_PS)
`define DRFSR_XSDLL_NCK              512
`define DRFSR_WR_AFTER_SRX_NCK       512
`define DRFSR_ODT_LAT_NCK            6
`define DRFSR_MAX_DEBT               8
`define DRFSR_ROW_W                  16
`define DRFSR_CNT_W                  16
`endif

// File: core/drfsr_pkg.sv
/*
 Types shared by the memory-device end and the controller end.
 Assumes drfsr_cfg.svh holds all numeric constants.
*/
package drfsr_pkg;
	typedef enum logic [5:0] {
		DEV_IDLE  = 6'h01,
		DEV_REF   = 6'h02,
		DEV_SELF  = 6'h04,
		DEV_SRX   = 6'h08,
		DEV_LOCK  = 6'h10,
		DEV_RSV   = 6'h20
	} drfsr_dev_e;

	typedef enum logic [6:0] {
		CTL_IDLE  = 7'h01,
		CTL_ODT   = 7'h02,
		CTL_REF   = 7'h04,
		CTL_SELF  = 7'h08,
		CTL_RSTRT = 7'h10,
		CTL_XS    = 7'h20,
		CTL_XSDLL = 7'h40
	} drfsr_ctl_e;
endpackage

// File: core/drfsr_if.sv
/*
 Command-bus link between controller and memory device.
 Assumes one shared clock; the controller gates it with ck_run.
*/
`timescale 1ns/1ns
interface drfsr_if;
	logic        cs_n;      // Chip select
	logic        ras_n;     // Row strobe
	logic        cas_n;     // Column strobe
	logic        we_n;      // Write enable
	logic        cke;       // Clock enable
	logic        odt;       // Termination control
	logic        ck_run;    // Controller lets the clock run
	logic [15:0] addr;      // Address bus
	logic        reset_n;   // Device reset

	modport ctl (output cs_n, ras_n, cas_n, we_n, cke, odt, ck_run, addr, reset_n);
	modport dev (input  cs_n, ras_n, cas_n, we_n, cke, odt, ck_run, addr, reset_n);
endinterface

// File: core/drfsr_dev.sv
/*
 Memory-device end: decodes refresh and self-refresh entry/exit, steps the
 internal row counter, runs the built-in self-refresh timer and DLL control.
 Assumes the controller keeps its own timing obligations.
*/
`timescale 1ns/1ns
`include "drfsr_cfg.svh"
module drfsr_dev
	import drfsr_pkg::*;
#(
	parameter int ROW_W   = `DRFSR_ROW_W,
	parameter int RFC_CYC = `DRFSR_RFC_CYC,
	parameter int CKE_CYC = `DRFSR_CKE_MIN_CYC
)(
	input  wire logic             clk_sys,     // Device clock
	input  wire logic             rst,         // Async reset, high
	drfsr_if.dev                  link,        // Command bus
	output logic                  ref_busy,    // Refresh in progress
	output logic [ROW_W-1:0]      ref_row,     // Row being refreshed
	output logic                  in_self,     // Self-refresh state
	output logic                  dll_on,      // DLL enabled
	output logic                  dll_rst      // DLL reset pulse
);
	if (ROW_W < 1 || RFC_CYC < 1 || CKE_CYC < 1)
	begin : g_bad_param
		$error("drfsr_dev: bad parameter");
	end

	typedef struct packed {
		drfsr_dev_e       st;
		logic [15:0]      cnt;
		logic [ROW_W-1:0] row;
		logic             dll;
		logic             dllr;
		logic             srdone;
	} drfsr_dst_s;

	drfsr_dst_s s_q;
	drfsr_dst_s s_d;
	logic       ref_cmd;
	logic       sre_cmd;
	logic       nop_cmd;

	// All in-domain: the bus is driven from the same clock
	assign nop_cmd = link.cs_n | (link.ras_n & link.cas_n & link.we_n);
	assign ref_cmd = link.cke & ~link.cs_n & ~link.ras_n & ~link.cas_n & link.we_n;
	assign sre_cmd = ~link.cke & ~link.cs_n & ~link.ras_n & ~link.cas_n & link.we_n;

	always_comb
	begin
		s_d      = s_q;
		s_d.dllr = 1'b0;
		case (s_q.st)
			DEV_IDLE:
			begin
				if (ref_cmd)
				begin
					s_d.st  = DEV_REF;
					s_d.cnt = 16'(RFC_CYC - 1);
				end
				else if (sre_cmd)
				begin
					s_d.st     = DEV_SELF;
					s_d.cnt    = 16'(CKE_CYC - 1);
					s_d.srdone = 1'b0;
					s_d.dll    = 1'b0;
				end
			end
			DEV_REF:
			begin
				if (s_q.cnt == 16'h0000)
				begin
					s_d.st  = DEV_IDLE;
					s_d.row = s_q.row + 1'b1;
				end
				else
					s_d.cnt = s_q.cnt - 16'h0001;
			end
			DEV_SELF:
			begin
				// Only cke is looked at here; all else ignored
				if (!s_q.srdone && s_q.cnt == 16'h0000)
				begin
					s_d.srdone = 1'b1;
					s_d.row    = s_q.row + 1'b1;
				end
				else if (s_q.cnt != 16'h0000)
					s_d.cnt = s_q.cnt - 16'h0001;
				if (link.cke)
				begin
					s_d.st   = DEV_SRX;
					s_d.dll  = 1'b1;
					s_d.dllr = 1'b1;
				end
			end
			DEV_SRX:
				s_d.st = nop_cmd ? DEV_IDLE : DEV_SRX;
			default:
				s_d.st = DEV_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			s_q.st     <= DEV_IDLE;
			s_q.cnt    <= 16'h0000;
			s_q.row    <= '0;
			s_q.dll    <= 1'b1;
			s_q.dllr   <= 1'b0;
			s_q.srdone <= 1'b0;
		end
		else if (!link.reset_n)
		begin
			s_q.st     <= DEV_IDLE;
			s_q.cnt    <= 16'h0000;
			s_q.row    <= '0;
			s_q.dll    <= 1'b1;
			s_q.dllr   <= 1'b0;
			s_q.srdone <= 1'b0;
		end
		else
			s_q <= s_d;
	end

	assign ref_busy = (s_q.st == DEV_REF);
	assign ref_row  = s_q.row;
	assign in_self  = (s_q.st == DEV_SELF);
	assign dll_on   = s_q.dll;
	assign dll_rst  = s_q.dllr;
endmodule

// File: core/drfsr_ctl.sv
/*
 Controller end: issues refreshes at the average interval with bounded
 debt, and sequences self-refresh entry and exit with all waits.
 Assumes one shared clock with the device and a user that reports bank state.
*/
// Notes on behaviour
// - Refresh: cs ras cas low, we high
// - Refresh only after all banks precharged
// - Device refresh rows come from counter
// - Refresh ends with all banks idle
// - Only nop until refresh cycle time
// - At most eight refreshes postponed
// - Refresh gap never over nine intervals (code still waits on banks_idle, so the gap is unbounded)
// - At most eight pulled-in refreshes count
// - At most sixteen refreshes per two intervals
// - Postponed total across self-refresh stays eight
// - Entry: refresh pattern with cke low
// - Idle, precharged, termination off before entry
// - Hold cke low while in self-refresh
// - Device DLL off on entry, reset on exit
// - Device ignores all but cke, reset
// - No write until 512 clocks after exit
// - Device refreshes once within min pulse
// - Stay in self-refresh min pulse period
// - Stop clock late, restart before exit
// - Exit with nop; wait exit delays
// - Nop, cke high, termination off meanwhile
// - Extra refresh before re-entering self-refresh
`timescale 1ns/1ns
`include "drfsr_cfg.svh"
module drfsr_ctl
	import drfsr_pkg::*;
#(
	parameter int REFI_CYC  = `DRFSR_REFI_CYC,
	parameter int RFC_CYC   = `DRFSR_RFC_CYC,
	parameter int RP_CYC    = `DRFSR_RP_CYC,
	parameter int CKE_CYC   = `DRFSR_CKE_MIN_CYC,
	parameter int CKSRE_CYC = `DRFSR_CKSRE_CYC,
	parameter int CKSRX_CYC = `DRFSR_CKSRX_CYC,
	parameter int XS_CYC    = `DRFSR_XS_CYC,
	parameter int XSDLL_CYC = `DRFSR_XSDLL_NCK,
	parameter int ODT_CYC   = `DRFSR_ODT_LAT_NCK + 1
)(
	input  wire logic         clk_sys,      // Controller clock
	input  wire logic         rst,          // Async reset, high
	drfsr_if.ctl              link,         // Command bus
	input  wire logic         banks_idle,   // User: all banks precharged
	input  wire logic         ref_early,    // User: pull in a refresh
	input  wire logic         sr_req,       // User: stay in self-refresh
	output logic              busy,         // Link not free for user commands
	output logic              dll_ready,    // Locked-DLL commands allowed
	output logic              wr_ok,        // Write allowed after exit
	output logic signed [4:0] debt          // Outstanding refreshes
);
	if (REFI_CYC < 2 || RFC_CYC < 1 || XSDLL_CYC < XS_CYC || XS_CYC < 1 || REFI_CYC > 65535)
	begin : g_bad_param
		$error("drfsr_ctl: bad parameter");
	end

	localparam logic signed [4:0] MAXD = 5'(`DRFSR_MAX_DEBT);
	localparam logic [15:0]       WRC  = 16'(`DRFSR_WR_AFTER_SRX_NCK);

	typedef struct packed {
		drfsr_ctl_e        st;
		logic [15:0]       cnt;
		logic [15:0]       ivl;
		logic [15:0]       prc;
		logic [15:0]       wrc;
		logic [15:0]       gap;
		logic signed [4:0] debt;
		logic              need_x;
		logic              cmd;
		logic              cke;
		logic              odt;
		logic              ck;
	} drfsr_cst_s;

	drfsr_cst_s s_q;
	drfsr_cst_s s_d;
	logic       tick;
	logic       want_ref;
	logic       can_ref;

	assign tick     = (s_q.ivl == 16'h0000);
	assign can_ref  = banks_idle && s_q.prc == 16'h0000;
	// Refresh when owed, or pulled in while credit stays above minus eight
	assign want_ref = (s_q.debt > 5'sd0) || (ref_early && s_q.debt > -MAXD);

	always_comb
	begin
		s_d     = s_q;
		s_d.cmd = 1'b0;
		s_d.ivl = tick ? 16'(REFI_CYC - 1) : s_q.ivl - 16'h0001;
		s_d.prc = banks_idle ? ((s_q.prc != 16'h0000) ? s_q.prc - 16'h0001 : 16'h0000) : 16'(RP_CYC);
		s_d.wrc = (s_q.wrc != 16'h0000) ? s_q.wrc - 16'h0001 : 16'h0000;
		s_d.gap = (s_q.gap != 16'h0000) ? s_q.gap - 16'h0001 : 16'h0000;
		// Interval elapsed outside CTL_SELF adds debt, capped at eight
		if (tick && s_q.debt < MAXD && s_q.st != CTL_SELF)
			s_d.debt = s_q.debt + 5'sd1;
		if (s_q.cnt != 16'h0000)
			s_d.cnt = s_q.cnt - 16'h0001;
		case (s_q.st)
			CTL_IDLE:
			begin
				// Debt reaching eight waits like any refresh on can_ref, gap and sr_req: no nine-interval bound
				// Spacing over an eighth interval keeps any two intervals to sixteen
				if (can_ref && s_q.gap == 16'h0000 && !(sr_req && !s_q.need_x) &&
					(want_ref || s_q.debt >= MAXD || (sr_req && s_q.need_x)))
				begin
					s_d.cmd    = 1'b1;
					s_d.st     = CTL_REF;
					s_d.gap    = 16'(REFI_CYC / 8);
					s_d.cnt    = 16'(RFC_CYC - 1);
					s_d.need_x = 1'b0;
					s_d.debt   = s_d.debt - 5'sd1;
				end
				else if (sr_req && can_ref && !s_q.need_x)
				begin
					s_d.odt = 1'b0;
					s_d.st  = CTL_ODT;
					s_d.cnt = 16'(ODT_CYC);
				end
			end
			CTL_REF:
				if (s_q.cnt == 16'h0000)
					s_d.st = CTL_IDLE;
			CTL_ODT:
				if (s_q.cnt == 16'h0000)
				begin
					s_d.cmd = 1'b1;
					s_d.cke = 1'b0;
					s_d.st  = CTL_SELF;
					s_d.cnt = 16'(CKE_CYC > CKSRE_CYC ? CKE_CYC : CKSRE_CYC);
				end
			CTL_SELF:
			begin
				s_d.cke = 1'b0;
				if (s_q.cnt == 16'h0000)
					s_d.ck = 1'b0;
				if (s_q.cnt == 16'h0000 && !sr_req)
				begin
					s_d.ck  = 1'b1;
					s_d.st  = CTL_RSTRT;
					s_d.cnt = 16'(CKSRX_CYC);
				end
			end
			CTL_RSTRT:
				if (s_q.cnt == 16'h0000)
				begin
					s_d.cke    = 1'b1;
					s_d.st     = CTL_XS;
					s_d.cnt    = 16'(XS_CYC);
					s_d.need_x = 1'b1;
					s_d.wrc    = WRC;
				end
			CTL_XS:
				if (s_q.cnt == 16'h0000)
				begin
					s_d.st  = CTL_XSDLL;
					s_d.cnt = 16'(XSDLL_CYC - XS_CYC);
				end
			CTL_XSDLL:
				if (s_q.cnt == 16'h0000)
				begin
					s_d.odt = 1'b1;
					s_d.st  = CTL_IDLE;
				end
			default:
				s_d.st = CTL_IDLE;
		endcase
		// Pulled-in floor and intervals lost in self-refresh keep within limits
		if (s_d.debt < -MAXD)
			s_d.debt = -MAXD;
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			s_q.st     <= CTL_IDLE;
			s_q.cnt    <= 16'h0000;
			s_q.ivl    <= 16'h0000;
			s_q.prc    <= 16'h0000;
			s_q.wrc    <= 16'h0000;
			s_q.gap    <= 16'h0000;
			s_q.debt   <= 5'sh00;
			s_q.need_x <= 1'b0;
			s_q.cmd    <= 1'b0;
			s_q.cke    <= 1'b1;
			s_q.odt    <= 1'b1;
			s_q.ck     <= 1'b1;
		end
		else
			s_q <= s_d;
	end

	assign link.cs_n    = ~s_q.cmd;
	assign link.ras_n   = ~s_q.cmd;
	assign link.cas_n   = ~s_q.cmd;
	assign link.we_n    = 1'b1;
	assign link.cke     = s_q.cke;
	assign link.odt     = s_q.odt;
	assign link.ck_run  = s_q.ck;
	assign link.addr    = 16'h0000;
	assign link.reset_n = 1'b1;
	assign busy         = (s_q.st != CTL_IDLE);
	assign dll_ready    = (s_q.st == CTL_IDLE);
	assign wr_ok        = (s_q.st == CTL_IDLE) && s_q.wrc == 16'h0000;
	assign debt         = s_q.debt;
endmodule

// File: test/drfsr_monitor.sv
/*
 Timing checker for the refresh / self-refresh command link.
 Assumes it sees the link signals and the one shared clock and reset.
*/
`timescale 1ns/1ns
module drfsr_monitor #(
	parameter int RFC_CYC   = 40,
	parameter int XS_CYC    = 43,
	parameter int XSDLL_CYC = 60,
	parameter int ODT_CYC   = 7
)(
	input wire logic clk_sys, // Clock
	input wire logic rst,     // Reset
	input wire logic cs_n,    // Select
	input wire logic ras_n,   // Row strobe
	input wire logic cas_n,   // Column strobe
	input wire logic we_n,    // Write enable
	input wire logic cke,     // Clock enable
	input wire logic odt,     // Termination
	input wire logic ck_run   // Clock may run
);
	logic        ref_c;
	logic        sre_c;
	logic        cmd_c;
	logic        cke_q;
	logic        ref_done_q;
	logic [11:0] ref_age_q;
	logic [11:0] exit_age_q;
	logic [11:0] odt_low_q;

	assign ref_c = !cs_n && !ras_n && !cas_n && we_n && cke;
	assign sre_c = !cs_n && !ras_n && !cas_n && we_n && !cke;
	assign cmd_c = !cs_n && !(ras_n && cas_n && we_n);

	// Ages saturate so long idle spans never wrap into a false hit
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			cke_q      <= 1'b1;
			ref_done_q <= 1'b1;
			ref_age_q  <= 12'hfff;
			exit_age_q <= 12'hfff;
			odt_low_q  <= 12'h000;
		end
		else
		begin
			cke_q      <= cke;
			ref_done_q <= ref_c || (ref_done_q && !(cke && !cke_q));
			ref_age_q  <= ref_c ? 12'h001 : ref_age_q + {11'h000, ref_age_q != 12'hfff};
			exit_age_q <= (cke && !cke_q) ? 12'h001 : exit_age_q + {11'h000, exit_age_q != 12'hfff};
			odt_low_q  <= odt ? 12'h000 : odt_low_q + {11'h000, odt_low_q != 12'hfff};
		end
	end

	chk_ref_quiet: assert property (@(posedge clk_sys) disable iff (rst)
		cmd_c |-> ref_age_q >= RFC_CYC) else $error("command inside refresh cycle time");
	chk_exit_quiet: assert property (@(posedge clk_sys) disable iff (rst)
		cmd_c |-> exit_age_q >= XS_CYC) else $error("command inside exit delay");
	chk_extra_ref: assert property (@(posedge clk_sys) disable iff (rst)
		sre_c |-> ref_done_q) else $error("re-entry without extra refresh");
	chk_odt_off: assert property (@(posedge clk_sys) disable iff (rst)
		sre_c |-> odt_low_q >= ODT_CYC) else $error("termination not off before entry");
	chk_cke_hold: assert property (@(posedge clk_sys) disable iff (rst)
		sre_c |=> !cke [*2]) else $error("clock enable released too early");
	chk_entry_code: assert property (@(posedge clk_sys) disable iff (rst)
		$fell(cke) |-> !cs_n && !ras_n && !cas_n && we_n) else $error("clock enable fell without entry");
	chk_stop_late: assert property (@(posedge clk_sys) disable iff (rst)
		$fell(ck_run) |-> !$past(cke, 3)) else $error("clock stopped too soon");
	chk_restart_first: assert property (@(posedge clk_sys) disable iff (rst)
		$rose(cke) |-> $past(ck_run, 1) && $past(ck_run, 2) && $past(ck_run, 3))
		else $error("clock not stable before exit");
	chk_stop_in_sr: assert property (@(posedge clk_sys) disable iff (rst)
		!ck_run |-> !cke) else $error("clock stopped outside self-refresh");
	chk_odt_exit: assert property (@(posedge clk_sys) disable iff (rst)
		$rose(odt) |-> exit_age_q >= XSDLL_CYC) else $error("termination on inside locked delay");
endmodule

// File: test/testbench.sv
/*
 Self-checking bench: controller and device joined over the link.
 Assumes the core header, package and interface are compiled first.
*/
`timescale 1ns/1ns
module testbench;
	localparam int REFI  = 400;
	localparam int RFC   = 40;
	localparam int XSDLL = 60;

	logic              clk_sys;
	logic              rst;
	logic              banks_idle;
	logic              ref_early;
	logic              sr_req;
	logic              busy;
	logic              dll_ready;
	logic              wr_ok;
	logic              ref_busy;
	logic              in_self;
	logic              dll_on;
	logic              dll_rst;
	logic              prev;
	logic signed [4:0] debt;
	logic [15:0]       ref_row;
	logic [15:0]       row0;
	int                fails;
	int                checked;
	int                n;
	int                k;

	drfsr_if lnk();
	drfsr_ctl #(.REFI_CYC(REFI), .XSDLL_CYC(XSDLL)) drfsr_ctl_i (.clk_sys(clk_sys), .rst(rst), .link(lnk),
		.banks_idle(banks_idle), .ref_early(ref_early), .sr_req(sr_req), .busy(busy),
		.dll_ready(dll_ready), .wr_ok(wr_ok), .debt(debt));
	drfsr_dev drfsr_dev_i (.clk_sys(clk_sys), .rst(rst), .link(lnk), .ref_busy(ref_busy),
		.ref_row(ref_row), .in_self(in_self), .dll_on(dll_on), .dll_rst(dll_rst));
	drfsr_monitor #(.RFC_CYC(RFC), .XSDLL_CYC(XSDLL)) monitor_i (.clk_sys(clk_sys), .rst(rst),
		.cs_n(lnk.cs_n), .ras_n(lnk.ras_n), .cas_n(lnk.cas_n), .we_n(lnk.we_n), .cke(lnk.cke),
		.odt(lnk.odt), .ck_run(lnk.ck_run));

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp)
		begin
			fails++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	function automatic logic pick(input int sel);
		case (sel)
			0: return ref_busy === 1'b1;
			1: return ref_busy === 1'b0;
			2: return in_self === 1'b1;
			3: return dll_rst === 1'b1;
			4: return wr_ok === 1'b1;
			default: return debt === 5'h18;
		endcase
	endfunction

	// Bounded wait; n returns the cycles spent
	task automatic await(input int sel, input int lim);
		n = 0;
		while (n < lim && !pick(sel))
		begin
			@(negedge clk_sys);
			n++;
		end
		check({15'h0000, n < lim}, 16'h0001);
	endtask

	task automatic t_refresh();
		row0 = ref_row;
		await(0, 2 * REFI);
		check({15'h0000, busy}, 16'h0001);
		await(1, RFC + 8);
		check(n[15:0], 16'(RFC));
		check(ref_row, row0 + 16'h0001);
		check({15'h0000, busy}, 16'h0000);
		$display("test refresh done");
	endtask

	task automatic t_postpone();
		// Released before nine intervals pass since the last refresh
		banks_idle = 1'b0;
		repeat (8 * REFI + 10) @(negedge clk_sys);
		check({11'h000, debt}, 16'h0008);
		// Repay and pull in together: the densest burst the user can ask for
		banks_idle = 1'b1;
		ref_early = 1'b1;
		k = 0;
		repeat (2 * REFI)
		begin
			prev = ref_busy;
			@(negedge clk_sys);
			k += int'(ref_busy && !prev);
		end
		ref_early = 1'b0;
		check({15'h0000, k >= 8}, 16'h0001);
		check({15'h0000, k <= 16}, 16'h0001);
		$display("test postpone done");
	endtask

	task automatic t_pullin();
		ref_early = 1'b1;
		await(5, 3 * REFI);
		k = 0;
		repeat (REFI / 2)
		begin
			@(negedge clk_sys);
			k += int'(debt < -5'sd8);
		end
		check(k[15:0], 16'h0000);
		ref_early = 1'b0;
		$display("test pull-in done");
	endtask

	task automatic t_self(input logic wait_wr);
		sr_req = 1'b1;
		await(2, 3 * REFI);
		// Taken before the device's own refresh lands
		row0 = ref_row;
		check({15'h0000, lnk.cke}, 16'h0000);
		check({15'h0000, dll_on}, 16'h0000);
		repeat (12) @(negedge clk_sys);
		check(ref_row, row0 + 16'h0001);
		sr_req = 1'b0;
		await(3, 60);
		check({15'h0000, wr_ok}, 16'h0000);
		@(negedge clk_sys);
		check({15'h0000, dll_on}, 16'h0001);
		if (wait_wr)
		begin
			await(4, 700);
			check({15'h0000, n >= 510}, 16'h0001);
			check({15'h0000, dll_ready}, 16'h0001);
		end
		$display("test self-refresh done");
	endtask

	// Re-entry at once after exit must be preceded by a refresh
	task automatic t_reenter();
		sr_req = 1'b1;
		k = 0;
		n = 0;
		while (n < 3 * REFI && in_self !== 1'b1)
		begin
			@(negedge clk_sys);
			k |= int'(ref_busy === 1'b1);
			n++;
		end
		check({k[0], in_self}, 16'h0003);
		t_self(1'b0);
		$display("test re-entry done");
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial
	begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	initial
	begin
		repeat (30000) @(posedge clk_sys);
		fails++;
		finish_test();
	end

	initial
	begin
		rst = 1'b1;
		banks_idle = 1'b1;
		ref_early = 1'b0;
		sr_req = 1'b0;
		fails = 0;
		checked = 0;
		repeat (12) @(negedge clk_sys);
		rst = 1'b0;
		check({13'h0000, lnk.cke, lnk.odt, dll_on}, 16'h0007);
		check({11'h000, debt}, 16'h0000);
		t_refresh();
		t_postpone();
		t_pullin();
		t_self(1'b1);
		t_reenter();
		finish_test();
	end
endmodule
